// *** hw/mrxcs_consts.svh ***
// Offsets, field positions, reset values and limits for the receive
// setup and status block. Assumes inclusion by bare name.
`ifndef MRXCS_CONSTS_SVH
`define MRXCS_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define MRXCS_OFF_SETUP   4'h0
`define MRXCS_OFF_STATUS  4'h4
`define MRXCS_OFF_TXSTAT  4'h8
`define MRXCS_OFF_RXSTAT  4'hC

// ****************************************
// Receive setup word fields
// ****************************************
`define MRXCS_B_RST    0
`define MRXCS_B_EN     1
`define MRXCS_B_VLAN   2
`define MRXCS_B_FCS    3
`define MRXCS_B_JUMBO  4
`define MRXCS_B_FC     5
`define MRXCS_B_PRE    7
`define MRXCS_B_LTD    8
`define MRXCS_B_CLD    9
`define MRXCS_B_FINH   10
`define MRXCS_B_MTUEN  14
`define MRXCS_MTU_HI   30
`define MRXCS_MTU_LO   16
`define MRXCS_SETUP_MASK  32'h7FFF_47BF
`define MRXCS_SETUP_RST   32'h0000_0000

// ****************************************
// Frame length limits and bus answers
// ****************************************
`define MRXCS_LEN_STD   15'h05EE
`define MRXCS_LEN_VLAN  15'h05F2
`define MRXCS_LEN_MIN   15'h0040
`define MRXCS_RESP_OK   2'h0
`define MRXCS_RESP_ERR  2'h2

`endif

// *** hw/mrxcs_pkg.sv ***
// Types shared by the receive setup and status block.
// Assumes nothing beyond a SystemVerilog compiler.
package mrxcs_pkg;

  // Summary of one received frame from the receive datapath.
  typedef struct packed {
    logic        done;
    logic [14:0] len;
    logic        vlan;
    logic        ctrl;
    logic        pause;
    logic        lt_err;
    logic        fcs_err;
  } mrxcs_rxf_s;

  // Verdict on one received frame back to the datapath.
  typedef struct packed {
    logic valid;
    logic good;
    logic pass;
    logic too_long;
    logic keep_pre;
    logic keep_fcs;
  } mrxcs_rxv_s;

  // What the reconciliation sublayer puts on the transmit side.
  typedef enum logic [1:0] {
    MRXCS_RS_DATA,
    MRXCS_RS_RFAULT,
    MRXCS_RS_IDLE
  } mrxcs_rs_e;

endpackage

// *** hw/mrxcs_top.sv ***
// Receive setup word, fault handling and per-frame statistics.
// Assumes one clock, synchronous inputs and an AXI4-Lite master.
//
// What this block does
// - MTU enabled: size field caps frame length.
// - MTU disabled: jumbo and VLAN pick limit.
// - Local fault received: send remote fault.
// - Remote fault received: send idle words.
// - Fault inhibit set: always send data.
// - Control length check disable bit honoured.
// - Length/type checks skipped when disabled.
// - Preamble kept or discarded per bit.
// - Pause frames inhibit transmitter or pass.
// - Jumbo bit removes the upper length limit while MTU is disabled.
// - FCS passed or stripped per bit.
// - FCS always checked.
// - VLAN enable raises limit to 1522.
// - VLAN disabled: no stats for tagged frames, limit 1518.
// - Receiver works only while enabled.
// - Receiver reset bit holds receiver reset.
// - Status bit 1 shows remote fault.
// - Status bit 0 shows local fault.
// - Everything runs on the core clock.
// - Transmit stats word with valid strobe.
// - Receive stats word with valid strobe.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mrxcs_consts.svh"

module mrxcs_top #(
  parameter int ADDR_W = 4
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 srst,
  // AXI4-Lite register slave.
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Reconciliation sublayer.
  input  wire logic                 rs_local_fault,
  input  wire logic                 rs_remote_fault,
  output mrxcs_pkg::mrxcs_rs_e      rs_tx_sel,
  output logic [1:0]                fault_status,
  // Receive datapath.
  input  wire mrxcs_pkg::mrxcs_rxf_s rx_frame,
  output mrxcs_pkg::mrxcs_rxv_s     rx_verdict,
  output logic                      rx_core_rst,
  output logic                      pause_inhibit,
  output logic [29:0]               rx_stat_vec,
  output logic                      rx_stat_valid,
  // Transmit statistics.
  input  wire logic                 tx_done,
  input  wire logic [25:0]          tx_flags,
  output logic [25:0]               tx_stat_vec,
  output logic                      tx_stat_valid
);
  import mrxcs_pkg::*;

  if (ADDR_W < 4) begin : g_bad_addr
    $error("ADDR_W must be at least 4");
  end

  // ****************************************
  // Register bus slave
  // ****************************************
  logic              awready_ff, nxt_awready;
  logic              wready_ff, nxt_wready;
  logic              bvalid_ff, nxt_bvalid;
  logic [1:0]        bresp_ff, nxt_bresp;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0]       wdata_ff, nxt_wdata;
  logic [3:0]        wstrb_ff, nxt_wstrb;
  logic              arready_ff, nxt_arready;
  logic              rvalid_ff, nxt_rvalid;
  logic [1:0]        rresp_ff, nxt_rresp;
  logic [31:0]       rdata_ff, nxt_rdata;
  logic [31:0]       setup_ff, nxt_setup;
  logic [31:0]       wr_merge;
  logic              do_wr;
  logic              wr_hit;
  logic              rd_hit;

  // Merges the written bytes into the current setup word.
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wr_merge[b*8 +: 8] = wstrb_ff[b] ? wdata_ff[b*8 +: 8]
                                            : setup_ff[b*8 +: 8];
  end

  assign do_wr  = !awready_ff && !wready_ff && !bvalid_ff;
  assign wr_hit = (awaddr_ff >> 4) == '0;
  assign rd_hit = (s_axi_araddr >> 4) == '0;

  always_comb begin
    nxt_awready = awready_ff;
    nxt_wready  = wready_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_setup   = setup_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_awready = '0;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_wready = '0;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end
    if (do_wr) begin
      nxt_bvalid = '1;
      nxt_bresp  = wr_hit ? `MRXCS_RESP_OK : `MRXCS_RESP_ERR;
      // Reserved bits are never stored and read back as zero.
      if (wr_hit && awaddr_ff[3:2] == 2'(`MRXCS_OFF_SETUP >> 2)) begin
        nxt_setup = wr_merge & `MRXCS_SETUP_MASK;
      end
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid  = '0;
      nxt_awready = '1;
      nxt_wready  = '1;
    end
  end

  always_comb begin
    nxt_arready = arready_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_arready = '0;
      nxt_rvalid  = '1;
      nxt_rresp   = rd_hit ? `MRXCS_RESP_OK : `MRXCS_RESP_ERR;
      nxt_rdata   = '0;
      if (rd_hit) begin
        unique case (s_axi_araddr[3:2])
          2'(`MRXCS_OFF_SETUP >> 2):  nxt_rdata = setup_ff;
          2'(`MRXCS_OFF_STATUS >> 2): nxt_rdata = {30'h0, fault_status};
          2'(`MRXCS_OFF_TXSTAT >> 2): nxt_rdata = {6'h0, tx_stat_vec};
          default:                nxt_rdata = {2'h0, rx_stat_vec};
        endcase
      end
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid  = '0;
      nxt_arready = '1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      awready_ff <= '1;
      wready_ff  <= '1;
      bvalid_ff  <= '0;
      bresp_ff   <= `MRXCS_RESP_OK;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
      arready_ff <= '1;
      rvalid_ff  <= '0;
      rresp_ff   <= `MRXCS_RESP_OK;
      rdata_ff   <= '0;
      setup_ff   <= `MRXCS_SETUP_RST;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
      setup_ff   <= nxt_setup;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // ****************************************
  // Reconciliation sublayer fault handling
  // ****************************************
  mrxcs_rs_e  rs_sel_ff, nxt_rs_sel;
  logic [1:0] fault_ff, nxt_fault;
  logic       finh;

  assign finh = setup_ff[`MRXCS_B_FINH];

  always_comb begin
    nxt_fault = {rs_remote_fault, rs_local_fault};
    if (finh) begin
      nxt_rs_sel = MRXCS_RS_DATA;
    end else if (rs_local_fault) begin
      nxt_rs_sel = MRXCS_RS_RFAULT;
    end else if (rs_remote_fault) begin
      nxt_rs_sel = MRXCS_RS_IDLE;
    end else begin
      nxt_rs_sel = MRXCS_RS_DATA;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rs_sel_ff <= MRXCS_RS_DATA;
      fault_ff  <= '0;
    end else begin
      rs_sel_ff <= nxt_rs_sel;
      fault_ff  <= nxt_fault;
    end
  end

  assign rs_tx_sel    = rs_sel_ff;
  assign fault_status = fault_ff;

  // ****************************************
  // Receive frame checks and statistics
  // ****************************************
  mrxcs_rxv_s  verdict_ff, nxt_verdict;
  logic        rx_rst_ff, nxt_rx_rst;
  logic        pause_ff, nxt_pause;
  logic [29:0] rx_stat_ff, nxt_rx_stat;
  logic        rx_sv_ff, nxt_rx_sv;
  logic [14:0] max_len;
  logic        mtu_en;
  logic        vlan_en;
  logic        fire;
  logic        too_long;
  logic        lt_bad;
  logic        cl_bad;
  logic        good;

  assign mtu_en  = setup_ff[`MRXCS_B_MTUEN];
  assign vlan_en = setup_ff[`MRXCS_B_VLAN];

  always_comb begin
    // Frames count only while enabled and out of reset.
    fire = rx_frame.done && setup_ff[`MRXCS_B_EN]
           && !setup_ff[`MRXCS_B_RST];
    if (mtu_en) begin
      max_len = setup_ff[`MRXCS_MTU_HI:`MRXCS_MTU_LO];
    end else if (vlan_en && rx_frame.vlan) begin
      max_len = `MRXCS_LEN_VLAN;
    end else begin
      max_len = `MRXCS_LEN_STD;
    end
    too_long = (mtu_en || !setup_ff[`MRXCS_B_JUMBO])
               && rx_frame.len > max_len;
    lt_bad = rx_frame.lt_err && !setup_ff[`MRXCS_B_LTD];
    cl_bad = rx_frame.ctrl && rx_frame.len > `MRXCS_LEN_MIN
             && !setup_ff[`MRXCS_B_CLD];
    good = !rx_frame.fcs_err && !too_long && !lt_bad && !cl_bad;
    nxt_verdict.valid    = fire;
    nxt_verdict.good     = fire && good;
    nxt_verdict.too_long = fire && too_long;
    nxt_verdict.pass     = fire && good && !(rx_frame.pause
                           && setup_ff[`MRXCS_B_FC]);
    nxt_verdict.keep_pre = setup_ff[`MRXCS_B_PRE];
    nxt_verdict.keep_fcs = setup_ff[`MRXCS_B_FCS];
    nxt_pause  = fire && good && rx_frame.pause
                 && setup_ff[`MRXCS_B_FC];
    nxt_rx_rst = setup_ff[`MRXCS_B_RST];
    nxt_rx_sv  = fire && !(rx_frame.vlan && !vlan_en);
    nxt_rx_stat = rx_stat_ff;
    if (nxt_rx_sv) begin
      nxt_rx_stat = {8'h00, rx_frame.len, rx_frame.pause, rx_frame.vlan,
                     rx_frame.ctrl, lt_bad, too_long, rx_frame.fcs_err,
                     good};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      verdict_ff <= '0;
      rx_rst_ff  <= '0;
      pause_ff   <= '0;
      rx_stat_ff <= '0;
      rx_sv_ff   <= '0;
    end else begin
      verdict_ff <= nxt_verdict;
      rx_rst_ff  <= nxt_rx_rst;
      pause_ff   <= nxt_pause;
      rx_stat_ff <= nxt_rx_stat;
      rx_sv_ff   <= nxt_rx_sv;
    end
  end

  assign rx_verdict    = verdict_ff;
  assign rx_core_rst   = rx_rst_ff;
  assign pause_inhibit = pause_ff;
  assign rx_stat_vec   = rx_stat_ff;
  assign rx_stat_valid = rx_sv_ff;

  // ****************************************
  // Transmit statistics
  // ****************************************
  logic [25:0] tx_stat_ff, nxt_tx_stat;
  logic        tx_sv_ff, nxt_tx_sv;

  always_comb begin
    nxt_tx_sv   = tx_done;
    nxt_tx_stat = tx_done ? tx_flags : tx_stat_ff;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_stat_ff <= '0;
      tx_sv_ff   <= '0;
    end else begin
      tx_stat_ff <= nxt_tx_stat;
      tx_sv_ff   <= nxt_tx_sv;
    end
  end

  assign tx_stat_vec   = tx_stat_ff;
  assign tx_stat_valid = tx_sv_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_mtu_cap: assert property (
    fire && mtu_en && rx_frame.len > setup_ff[30:16] |=> !rx_verdict.good)
    else $error("Frame over the MTU size was judged good.");
  chk_std_cap: assert property (
    fire && !mtu_en && !setup_ff[`MRXCS_B_JUMBO] && !rx_frame.vlan
    && rx_frame.len > `MRXCS_LEN_STD |=> rx_verdict.too_long)
    else $error("Untagged frame over 1518 bytes not marked long.");
  chk_lf_rf: assert property (
    !finh && rs_local_fault |=> rs_tx_sel == MRXCS_RS_RFAULT)
    else $error("Local fault did not select remote fault.");
  chk_rf_idle: assert property (
    !finh && !rs_local_fault && rs_remote_fault
    |=> rs_tx_sel == MRXCS_RS_IDLE)
    else $error("Remote fault did not select idle.");
  chk_inhibit: assert property (
    finh |=> rs_tx_sel == MRXCS_RS_DATA)
    else $error("Fault inhibit did not keep data.");
  chk_ctrl_len: assert property (
    fire && rx_frame.ctrl && !setup_ff[`MRXCS_B_CLD]
    && rx_frame.len > `MRXCS_LEN_MIN |=> !rx_verdict.good)
    else $error("Long control frame passed the length check.");
  chk_lt_err: assert property (
    fire && rx_frame.lt_err && !setup_ff[`MRXCS_B_LTD]
    |=> !rx_verdict.good)
    else $error("Length/type error was not flagged.");
  chk_flags: assert property (
    ##1 rx_verdict.keep_pre == $past(setup_ff[`MRXCS_B_PRE])
    && rx_verdict.keep_fcs == $past(setup_ff[`MRXCS_B_FCS]))
    else $error("Preamble or FCS keep flag is stale.");
  chk_pause: assert property (
    pause_inhibit |-> rx_verdict.good && !rx_verdict.pass)
    else $error("Pause inhibit without a held good frame.");
  chk_jumbo: assert property (
    fire && !mtu_en && setup_ff[`MRXCS_B_JUMBO]
    |=> !rx_verdict.too_long)
    else $error("Jumbo frame was marked long.");
  chk_fcs: assert property (
    fire && rx_frame.fcs_err |=> rx_verdict.valid && !rx_verdict.good)
    else $error("Frame with a bad FCS was judged good.");
  chk_vlan_cap: assert property (
    fire && !mtu_en && vlan_en && rx_frame.vlan
    && rx_frame.len == `MRXCS_LEN_VLAN |=> !rx_verdict.too_long)
    else $error("Tagged 1522 byte frame was marked long.");
  chk_vlan_stat: assert property (
    fire && rx_frame.vlan && !vlan_en |=> !rx_stat_valid)
    else $error("Tagged frame counted with VLAN disabled.");
  chk_rx_off: assert property (
    !setup_ff[`MRXCS_B_EN] |=> !rx_verdict.valid && !rx_stat_valid)
    else $error("Disabled receiver produced a verdict.");
  chk_rx_rst: assert property (
    setup_ff[`MRXCS_B_RST] |=> rx_core_rst)
    else $error("Receiver reset bit did not hold reset.");
  chk_fault_bits: assert property (
    ##1 fault_status == $past({rs_remote_fault, rs_local_fault}))
    else $error("Fault status does not follow the sublayer.");
  chk_tx_stat: assert property (
    tx_done |=> tx_stat_valid && tx_stat_vec == $past(tx_flags))
    else $error("Transmit statistics word not presented.");
  chk_rx_stat: assert property (
    rx_stat_valid |-> rx_verdict.valid
    && rx_stat_vec[0] == rx_verdict.good)
    else $error("Receive statistics strobe without a verdict.");

endmodule

`default_nettype wire

// *** tb/mrxcs_client.sv ***
// Client model: an AXI4-Lite master that writes and reads registers.
// Assumes one clock and the register map of the receive setup block.
`timescale 1ns/1ps
`default_nettype none
`include "mrxcs_consts.svh"
module mrxcs_client (
  // Clock.
  input  wire logic        clk,
  // Write channels.
  output logic [4:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels.
  output logic [4:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready,
  // High when an answer never came.
  output logic             hang
);
  // ********************
  // Idle values and bus cycles.
  // ********************
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hang} = '0;
  end

  // Released payloads are inverted so stale values are never trusted.
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= (a == 5'h00) ? (d & `MRXCS_SETUP_MASK) : d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~wdata;
      end
    end while (!bvalid && n < 64);
    r = bresp;
    bready <= 1'b0;
    if (n >= 64) hang <= 1'b1;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~araddr;
      end
    end while (!rvalid && n < 64);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 64) hang <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** tb/mac_rx_config_status_vectors_tb_top.sv ***
// Self-checking bench for the receive setup and status block.
// Assumes the client model in mrxcs_client.sv and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "mrxcs_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  num_errors++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module mac_rx_config_status_vectors_tb_top;
  import mrxcs_pkg::*;
  logic        clk, srst, hang, lf, rf, tx_done;
  logic [4:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, setup, d, s;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, fault_status, r;
  logic        rx_core_rst, pause_inhibit, rx_stat_valid, tx_stat_valid;
  logic [25:0] tx_flags, tx_stat_vec, last_tx;
  logic [29:0] rx_stat_vec, last_rx;
  mrxcs_rs_e   rs_tx_sel, es;
  mrxcs_rxf_s  rx_frame, f;
  mrxcs_rxv_s  rx_verdict;
  int          num_errors, checks_done;
  int          seed = 62;

  mrxcs_top #(.ADDR_W(5)) dut (.clk(clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rs_local_fault(lf),
    .rs_remote_fault(rf), .rs_tx_sel(rs_tx_sel), .fault_status(fault_status),
    .rx_frame(rx_frame), .rx_verdict(rx_verdict), .rx_core_rst(rx_core_rst),
    .pause_inhibit(pause_inhibit), .rx_stat_vec(rx_stat_vec),
    .rx_stat_valid(rx_stat_valid), .tx_done(tx_done), .tx_flags(tx_flags),
    .tx_stat_vec(tx_stat_vec), .tx_stat_valid(tx_stat_valid));

  mrxcs_client cl (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .hang(hang));

  // ********************
  // Clock, verdict and watchdogs.
  // ********************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    final_report();
  end

  always @(posedge hang) begin
    num_errors++;
    final_report();
  end

  // ********************
  // Setup writes and the frame model.
  // ********************
  task automatic put_setup(input logic [31:0] v);
    setup = v & `MRXCS_SETUP_MASK;
    cl.wr(5'h00, v, r);
    `CHK("setup bresp", `MRXCS_RESP_OK, r)
    cl.rd(5'h00, d, r);
    `CHK("setup read", setup, d)
    @(posedge clk);
    #1;
    `CHK("rx reset", setup[0], rx_core_rst)
  endtask

  task automatic frame(input mrxcs_rxf_s fr, input logic td,
                       input logic [25:0] tf);
    int          lim;
    logic        lng, g, act, sv_ok;
    mrxcs_rxv_s  ev;
    logic [29:0] sv;
    act = setup[1] && !setup[0];
    if (setup[14]) lim = int'(setup[30:16]);
    else if (setup[4]) lim = 32'h7FFF_FFFF;
    else if (fr.vlan && setup[2]) lim = 1522;
    else lim = 1518;
    lng = int'(fr.len) > lim;
    g = !fr.fcs_err && !lng && !(fr.lt_err && !setup[8]) &&
        !(fr.ctrl && fr.len > 15'd64 && !setup[9]);
    ev = '{act, act & g, act & g & !(fr.pause & setup[5]), act & lng,
           setup[7], setup[3]};
    sv = {8'h00, fr.len, fr.pause, fr.vlan, fr.ctrl,
          fr.lt_err & !setup[8], lng, fr.fcs_err, g};
    sv_ok = act && !(fr.vlan && !setup[2]);
    @(posedge clk);
    rx_frame <= fr;
    tx_done  <= td;
    tx_flags <= tf;
    @(posedge clk);
    rx_frame <= ~fr;
    tx_done  <= 1'b0;
    tx_flags <= ~tf;
    #1;
    `CHK("verdict", ev, rx_verdict)
    `CHK("pause", act & g & fr.pause & setup[5], pause_inhibit)
    `CHK("rx valid", sv_ok, rx_stat_valid)
    if (sv_ok) last_rx = sv;
    `CHK("rx vec", last_rx, rx_stat_vec)
    `CHK("tx valid", td, tx_stat_valid)
    if (td) last_tx = tf;
    `CHK("tx vec", last_tx, tx_stat_vec)
  endtask

  // ********************
  // Main sequence.
  // ********************
  initial begin
    srst = 1'b1;
    {lf, rf, tx_done, tx_flags, rx_frame} = '0;
    {last_rx, last_tx, num_errors, checks_done} = '0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    cl.rd(5'h00, d, r);
    `CHK("setup reset", 32'h0, d)
    for (int i = 0; i < 8; i++) begin
      put_setup({21'h0, i[2], 10'h002});
      @(posedge clk);
      lf <= i[0];
      rf <= i[1];
      repeat (2) @(posedge clk);
      #1;
      es = i[2] ? MRXCS_RS_DATA : i[0] ? MRXCS_RS_RFAULT :
           i[1] ? MRXCS_RS_IDLE : MRXCS_RS_DATA;
      `CHK("rs sel", es, rs_tx_sel)
      `CHK("fault status", i[1:0], fault_status)
      cl.rd(5'h04, d, r);
      `CHK("status read", {30'h0, i[1:0]}, d)
    end
    for (int i = 0; i < 8; i++) begin
      if (i % 4 == 0) put_setup({29'h0, i[2], 2'b10});
      f = '0;
      f.done = 1'b1;
      f.vlan = 1'b1;
      f.len = i[1] ? 15'd1522 + 15'(i[0]) : 15'd1518 + 15'(i[0]);
      frame(f, 1'b0, 26'h0);
    end
    for (int i = 0; i < 400; i++) begin
      if (i % 8 == 0) begin
        s = $random(seed);
        s[0] = ($random(seed) % 8) == 0;
        s[1] = ($random(seed) % 4) != 0;
        s[30:16] = 15'(1400 + ($random(seed) & 255));
        put_setup(s);
      end
      f = mrxcs_rxf_s'(21'($random(seed)));
      f.done = 1'b1;
      f.len = s[31] ? 15'(32 + ($random(seed) & 63))
                    : 15'(1300 + ($random(seed) & 511));
      frame(f, 1'($random(seed)), 26'($random(seed)));
    end
    cl.rd(5'h08, d, r);
    `CHK("tx read", {6'h0, last_tx}, d)
    cl.rd(5'h0C, d, r);
    `CHK("rx read", {2'h0, last_rx}, d)
    cl.wr(5'h04, 32'hFFFF_FFFF, r);
    `CHK("ro bresp", `MRXCS_RESP_OK, r)
    cl.wr(5'h10, 32'h0000_0002, r);
    `CHK("bad bresp", `MRXCS_RESP_ERR, r)
    cl.rd(5'h10, d, r);
    `CHK("bad rresp", `MRXCS_RESP_ERR, r)
    `CHK("bad rdata", 32'h0, d)
    cl.rd(5'h00, d, r);
    `CHK("setup kept", setup, d)
    @(posedge clk);
    {lf, rf} <= 2'b00;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    cl.rd(5'h00, d, r);
    `CHK("setup after reset", 32'h0, d)
    final_report();
  end
endmodule
`default_nettype wire
